// [verilog/rsc_pkg.sv]
// constants and types for the receive silo control block
// Operation
// - test pattern word has even bits 0 and odd bits 1.
// - status bit 15 selects test pattern instead of live received data.
// - stored data byte is OR of both line groups' data.
// - each entry stores the scanner's four-bit line number.
// - parity, framing, overrun flags stored, each ORed across both line groups.
// - push request sets a pending flag held until the write cycle ends.
// - toggling phase; push taken entering 0, pop taken entering 1.
// - accepted push drives write strobe for 170 ns.
// - then 30 ns pulse restarts scanner, increments level, clears pending push.
// - six-bit fill level reads in status bits 8 to 13.
// - full and empty both read level zero; storage-full bit sets only on a push attempt while full.
// - software alarm threshold in status bits 0 to 5, compared continuously.
// - data ready sets when level exceeds threshold, an entry is present and the valid bit is clear.
// - data ready requests interrupt only while receiver interrupt enable bit 6 set; storage-full bit requests it regardless.
// - read of character register sets valid bit 15 if entry present.
// - setting the valid bit clears data ready.
// - pop requested after read strobe ends with valid set; taken at phase 1.
// - accepted pop drives read-shift strobe for 100 ns.
// - then 30 ns pulse decrements level and clears valid bit.
// - data ready sets again when next entry arrives above threshold.
// - storage holds 64 entries of 16 bits with common controls.
// - character register: data 0-7, line 8-11, errors 12-14, valid 15.
// - push attempt while full sets storage-full bit.
`default_nettype none
package rsc_pkg;
  localparam int          CLK_NS        = 100;
  localparam int          WR_STB_NS     = 170;
  localparam int          RD_STB_NS     = 100;
  localparam int          DONE_NS       = 30;
  // least times round up
  localparam int          WR_STB_CYC    = (WR_STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RD_STB_CYC    = (RD_STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int          DONE_CYC      = (DONE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          DEPTH         = 64;
  localparam int          AW            = 6;
  localparam int          DW            = 16;
  localparam logic [15:0] TEST_WORD     = 16'hAAAA;
  // register byte addresses
  localparam logic [3:0]  ADDR_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_CHAR     = 4'h4;
  localparam logic [3:0]  ADDR_STAT     = 4'h8;
  localparam int          STAT_TEST     = 15;
  localparam int          STAT_LVL_LO   = 8;
  localparam int          STAT_LVL_HI   = 13;
  localparam int          STAT_ALARM_HI = 5;
  localparam int          CHAR_ERR_HI   = 14;
  localparam int          CHAR_VALID    = 15;
  localparam int          CTRL_RIE      = 6;
  localparam int          CTRL_FULL     = 14;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [2:0]  CNT_W0        = 3'h0;
  typedef enum logic [1:0] {RSC_IDLE, RSC_STB, RSC_DONE} rsc_seq_t;
endpackage
`default_nettype wire

// [verilog/rsc_top.sv]
// receive silo control: fifo, fill level, alarm, pop sequencing, axi4-lite slave
`timescale 1ns/100ps
`default_nettype none
module rsc_top
  import rsc_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  // receiver scanner side
  input  wire logic        i_push_req,
  input  wire logic [7:0]  i_data_group_a,
  input  wire logic [7:0]  i_data_group_b,
  input  wire logic [2:0]  i_err_group_a,
  input  wire logic [2:0]  i_err_group_b,
  input  wire logic [3:0]  i_line_number_bits,
  output logic             o_write_strobe,
  output logic             o_scan_restart,
  output logic             o_rx_int_req,
  // axi4-lite slave
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              req_s1;
    logic              req_s2;
    logic              req_d;
    logic              phase;
    logic              push_pend;
    logic              pop_pend;
    rsc_seq_t          wseq;
    logic [1:0]        wcnt;
    rsc_seq_t          rseq;
    logic [1:0]        rcnt;
    logic [AW-1:0]     wptr;
    logic [AW-1:0]     rptr;
    logic [AW-1:0]     level;
    logic              full;
    logic              data_ready;
    logic              char_valid;
    logic              read_act;
    logic              test_sel;
    logic [5:0]        alarm;
    logic              rie;
    logic              stor_full;
    logic              aw_got;
    logic [3:0]        aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              ar_got;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              int_req;
    logic              restart;
    logic              wstb;
  } rsc_state_t;

  rsc_state_t            st;
  rsc_state_t            next_st;
  logic [DW-1:0]         mem [DEPTH];
  logic [DW-1:0]         in_word;
  logic                  do_write;
  logic                  empty;
  logic [DW-1:0]         head;

  // ----------------------------------------------------------------
  // fifo storage
  // ----------------------------------------------------------------
  assign empty = (st.level == '0) && !st.full;
  assign head  = empty ? '0 : mem[st.rptr];

  always_comb begin
    if (st.test_sel) begin
      in_word = TEST_WORD;
    end else begin
      in_word = {1'b0, i_err_group_a | i_err_group_b,
                 i_line_number_bits,
                 i_data_group_a | i_data_group_b};
    end
  end

  // the array itself is not reset; emptiness comes from the cleared level
  always_ff @(posedge i_clk_sys) begin
    if (do_write) begin
      mem[st.wptr] <= in_word;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        rd_fire;
    logic        ovf;
    logic        rd_edge_up;
    logic        rd_edge_dn;
    logic        inc;
    logic        dec;
    logic [31:0] wd;
    rd_fire    = 1'b0;
    ovf        = 1'b0;
    rd_edge_up = 1'b0;
    rd_edge_dn = 1'b0;
    inc        = 1'b0;
    dec        = 1'b0;
    wd         = '0;
    do_write   = 1'b0;
    next_st    = st;

    // push request from scanner crosses in through two flops
    next_st.req_s1 = i_push_req;
    next_st.req_s2 = st.req_s1;
    next_st.req_d  = st.req_s2;
    next_st.phase  = !st.phase;
    next_st.restart = 1'b0;

    // write cycle
    if (st.req_s2 && !st.req_d && !st.push_pend) begin
      next_st.push_pend = 1'b1;
    end
    case (st.wseq)
      RSC_IDLE: begin
        // phase about to enter 0
        if (st.phase && st.push_pend) begin
          if (st.full) begin
            next_st.stor_full = 1'b1;
            ovf               = 1'b1;
            next_st.push_pend = 1'b0;
            next_st.restart   = 1'b1;
          end else begin
            next_st.wseq = RSC_STB;
            next_st.wcnt = 2'(WR_STB_CYC - 1);
            do_write     = 1'b1;
          end
        end
      end
      RSC_STB: begin
        if (st.wcnt == '0) begin
          next_st.wseq = RSC_DONE;
          next_st.wcnt = 2'(DONE_CYC - 1);
        end else begin
          next_st.wcnt = st.wcnt - 2'h1;
        end
      end
      RSC_DONE: begin
        if (st.wcnt == '0) begin
          next_st.wseq      = RSC_IDLE;
          next_st.push_pend = 1'b0;
          next_st.restart   = 1'b1;
          inc               = 1'b1;
        end else begin
          next_st.wcnt = st.wcnt - 2'h1;
        end
      end
      default: next_st.wseq = RSC_IDLE;
    endcase
    next_st.wstb = (next_st.wseq == RSC_STB);

    // read cycle
    case (st.rseq)
      RSC_IDLE: begin
        // phase about to enter 1
        if (!st.phase && st.pop_pend) begin
          next_st.rseq     = RSC_STB;
          next_st.rcnt     = 2'(RD_STB_CYC - 1);
          next_st.pop_pend = 1'b0;
        end
      end
      RSC_STB: begin
        if (st.rcnt == '0) begin
          next_st.rseq = RSC_DONE;
          next_st.rcnt = 2'(DONE_CYC - 1);
        end else begin
          next_st.rcnt = st.rcnt - 2'h1;
        end
      end
      RSC_DONE: begin
        if (st.rcnt == '0) begin
          next_st.rseq       = RSC_IDLE;
          next_st.char_valid = 1'b0;
          next_st.rptr       = st.rptr + 6'h01;
          dec                = 1'b1;
        end else begin
          next_st.rcnt = st.rcnt - 2'h1;
        end
      end
      default: next_st.rseq = RSC_IDLE;
    endcase

    if (do_write) begin
      next_st.wptr = st.wptr + 6'h01;
    end
    // push and pop both finish in a phase-0 cycle, so they can coincide; both at once holds
    if (inc && !dec) begin
      next_st.level = st.level + 6'h01;
      next_st.full  = (st.level == '1);
    end else if (dec && !inc) begin
      next_st.level = st.level - 6'h01;
      next_st.full  = 1'b0;
    end

    // ----------------------------------------------------------------
    // axi4-lite
    // ----------------------------------------------------------------
    next_st.awready = 1'b0;
    next_st.wready  = 1'b0;
    next_st.arready = 1'b0;
    if (i_awvalid && !st.aw_got && !st.awready && !st.bvalid) begin
      next_st.awready = 1'b1;
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && !st.w_got && !st.wready && !st.bvalid) begin
      next_st.wready = 1'b1;
      next_st.w_got  = 1'b1;
      next_st.w_data = i_wdata;
      next_st.w_strb = i_wstrb;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      wd             = st.w_data;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      case (st.aw_addr)
        ADDR_CTRL: begin
          if (st.w_strb[0]) begin
            next_st.rie = wd[CTRL_RIE];
          end
          // storage-full is cleared by writing zero; an overflow in the same cycle wins
          if (st.w_strb[1] && !wd[CTRL_FULL] && !ovf) begin
            next_st.stor_full = 1'b0;
          end
        end
        ADDR_STAT: begin
          if (st.w_strb[0]) begin
            next_st.alarm = wd[STAT_ALARM_HI:0];
          end
          if (st.w_strb[1]) begin
            next_st.test_sel = wd[STAT_TEST];
          end
        end
        ADDR_CHAR: ;
        default:   next_st.bresp = RESP_SLVERR;
      endcase
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end

    if (i_arvalid && !st.arready && !st.ar_got && !st.rvalid && !st.read_act) begin
      next_st.arready = 1'b1;
      next_st.ar_got  = 1'b1;
      next_st.rresp   = RESP_OKAY;
      next_st.rdata   = '0;
      case (i_araddr)
        ADDR_CTRL: begin
          next_st.rdata[CTRL_RIE]  = st.rie;
          next_st.rdata[CTRL_FULL] = st.stor_full;
        end
        ADDR_CHAR: begin
          rd_fire            = 1'b1;
          rd_edge_up         = !empty;
          next_st.rdata[CHAR_ERR_HI:0] = head[CHAR_ERR_HI:0];
          next_st.rdata[CHAR_VALID] = !empty || st.char_valid;
        end
        ADDR_STAT: begin
          next_st.rdata[STAT_ALARM_HI:0]          = st.alarm;
          next_st.rdata[STAT_LVL_HI:STAT_LVL_LO]  = st.level;
          next_st.rdata[STAT_TEST] = st.test_sel;
        end
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end
    // read data follows the address handshake by one cycle, never alongside it
    if (st.ar_got) begin
      next_st.ar_got = 1'b0;
      next_st.rvalid = 1'b1;
    end
    if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
      rd_edge_dn     = st.read_act;
    end
    // read strobe: high from address taken until the data is accepted
    if (rd_fire) begin
      next_st.read_act = 1'b1;
    end else if (rd_edge_dn) begin
      next_st.read_act = 1'b0;
    end
    if (rd_edge_up && st.rseq == RSC_IDLE && !st.pop_pend) begin
      next_st.char_valid = 1'b1;
    end
    if (rd_edge_dn && st.char_valid) begin
      next_st.pop_pend = 1'b1;
    end

    // data ready
    if (next_st.char_valid && !st.char_valid) begin
      next_st.data_ready = 1'b0;
    end else if (!empty && !st.char_valid && st.rseq == RSC_IDLE
                 && (st.level > st.alarm || st.full)) begin
      next_st.data_ready = 1'b1;
    end
    next_st.int_req = (next_st.data_ready && next_st.rie)
                      || next_st.stor_full;

    if (!i_rstn) begin
      next_st = '0;
      do_write = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_write_strobe = st.wstb;
  assign o_scan_restart = st.restart;
  assign o_rx_int_req   = st.int_req;
  assign o_awready      = st.awready;
  assign o_wready       = st.wready;
  assign o_bresp        = st.bresp;
  assign o_bvalid       = st.bvalid;
  assign o_arready      = st.arready;
  assign o_rdata        = st.rdata;
  assign o_rresp        = st.rresp;
  assign o_rvalid       = st.rvalid;
endmodule
`default_nettype wire

// [verif/rsc_scanner.sv]
// receiver line scanner model feeding the silo push side
`timescale 1ns/100ps
`default_nettype none
module rsc_scanner (
  input  wire logic       i_clk_sys,
  input  wire logic       i_scan_restart,
  output logic            o_push_req,
  output logic [7:0]      o_data_a,
  output logic [7:0]      o_data_b,
  output logic [2:0]      o_err_a,
  output logic [2:0]      o_err_b,
  output logic [3:0]      o_line
);
  initial begin
    o_push_req = 1'b0;
    {o_data_a, o_data_b, o_err_a, o_err_b, o_line} = '0;
  end

  // payload stays put until the restart; afterwards it is inverted so stale data cannot pass
  task automatic push(input logic [7:0] a, b, input logic [2:0] ea, eb, input logic [3:0] ln);
    repeat (2) @(posedge i_clk_sys);
    {o_data_a, o_data_b, o_err_a, o_err_b, o_line} <= {a, b, ea, eb, ln};
    o_push_req <= 1'b1;
    do begin
      @(negedge i_clk_sys);
    end while (!i_scan_restart);
    @(posedge i_clk_sys);
    o_push_req <= 1'b0;
    {o_data_a, o_data_b, o_err_a, o_err_b, o_line} <= ~{a, b, ea, eb, ln};
  endtask
endmodule
`default_nettype wire

// [verif/rsc_monitor.sv]
// concurrent checks on the receive silo control ports
`timescale 1ns/100ps
`default_nettype none
module rsc_monitor (
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  input  wire logic i_push_req,
  input  wire logic o_write_strobe,
  input  wire logic o_scan_restart,
  input  wire logic o_rx_int_req,
  input  wire logic o_bvalid,
  input  wire logic i_bready,
  input  wire logic o_rvalid,
  input  wire logic i_rready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  wstb_two_cyc_a: assert property (
    $rose(o_write_strobe) |=> o_write_strobe ##1 !o_write_strobe)
    else $error("write strobe not two cycles long");
  restart_follows_a: assert property (
    $fell(o_write_strobe) |-> ##[0:2] o_scan_restart)
    else $error("no scanner restart after write strobe");
  restart_pulse_a: assert property (
    o_scan_restart |=> !o_scan_restart)
    else $error("scanner restart longer than one cycle");
  stb_restart_excl_a: assert property (
    o_write_strobe |-> !o_scan_restart)
    else $error("restart during write strobe");
  push_served_a: assert property (
    $rose(i_push_req) |-> ##[3:20] o_scan_restart)
    else $error("push request not served in time");
  reset_quiet_a: assert property (
    $rose(i_rstn) |-> !o_rx_int_req && !o_write_strobe && !o_scan_restart)
    else $error("outputs active right after reset");
  wr_resp_ends_a: assert property (
    o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response not released");
  rd_resp_ends_a: assert property (
    o_rvalid && i_rready |=> !o_rvalid)
    else $error("read response not released");
endmodule
bind rsc_top rsc_monitor mon (.i_clk_sys, .i_rstn, .i_push_req, .o_write_strobe,
  .o_scan_restart, .o_rx_int_req, .o_bvalid, .i_bready, .o_rvalid, .i_rready);
`default_nettype wire

// [verif/receive_silo_control_bench.sv]
// self-checking bench for the receive silo control block
`timescale 1ns/100ps
`default_nettype none
module receive_silo_control_bench import rsc_pkg::*; ();
  typedef struct packed {
    logic [7:0] a, b;
    logic [2:0] ea, eb;
    logic [3:0] ln;
    logic       tst;
    logic [15:0] exp;
  } rsc_row_t;
  logic        clk, rstn, push, awvalid, wvalid, bready, arvalid, rready;
  logic        wstb, restart, int_req, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  dat_a, dat_b;
  logic [2:0]  err_a, err_b;
  logic [3:0]  line, awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [5:0]  lvl;
  int          num_errors, checked;
  rsc_row_t    rows [4] = '{
    '{8'h12, 8'h40, 3'h1, 3'h0, 4'h3, 1'b0, 16'h9352},
    '{8'h81, 8'h18, 3'h0, 3'h2, 4'hF, 1'b0, 16'hAF99},
    '{8'h00, 8'h00, 3'h4, 3'h3, 4'h0, 1'b0, 16'hF000},
    '{8'h5A, 8'hC3, 3'h7, 3'h7, 4'h9, 1'b1, 16'hAAAA}};

  rsc_top dut (.i_clk_sys(clk), .i_rstn(rstn), .i_push_req(push), .i_data_group_a(dat_a),
    .i_data_group_b(dat_b), .i_err_group_a(err_a), .i_err_group_b(err_b),
    .i_line_number_bits(line), .o_write_strobe(wstb), .o_scan_restart(restart),
    .o_rx_int_req(int_req), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready));
  rsc_scanner scan (.i_clk_sys(clk), .i_scan_restart(restart), .o_push_req(push),
    .o_data_a(dat_a), .o_data_b(dat_b), .o_err_a(err_a), .o_err_b(err_b), .o_line(line));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // flags are sampled mid-cycle, where they equal what the next rising edge sees
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  task automatic rd_(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  task automatic lvl_wait(input logic [5:0] e);
    int n;
    n = 0;
    do begin
      rd_(ADDR_STAT, rd, rsp);
      n++;
    end while (rd[13:8] !== e && n < 30);
    chk(32'(rd[13:8]), 32'(e));
  endtask

  task automatic int_is(input logic v);
    for (int n = 0; n < 10 && int_req !== v; n++) @(negedge clk);
    chk(32'(int_req), 32'(v));
  endtask

  task automatic put(input rsc_row_t r);
    scan.push(r.a, r.b, r.ea, r.eb, r.ln);
    lvl = lvl + 6'h01;
  endtask

  task automatic pop(input logic [15:0] e);
    rd_(ADDR_CHAR, rd, rsp);
    chk(32'(rd[15:0]), 32'(e));
    lvl = lvl - 6'h01;
    lvl_wait(lvl);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {num_errors, checked} = '0;
    lvl = 6'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    lvl_wait(6'h00);
    rd_(ADDR_CHAR, rd, rsp);
    chk(32'(rd[15]), 32'h0);
    rd_(4'hC, rd, rsp);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(4'hC, 32'h0, rsp);
    chk(32'(rsp), 32'(RESP_SLVERR));
    foreach (rows[i]) begin
      wr(ADDR_STAT, {16'h0, rows[i].tst, 9'h0, 6'h3F}, rsp);
      chk(32'(rsp), 32'(RESP_OKAY));
      put(rows[i]);
    end
    lvl_wait(6'h04);
    chk(32'(rsp), 32'(RESP_OKAY));
    chk(32'({rd[15], rd[5:0]}), 32'h7F);
    foreach (rows[i]) pop(rows[i].exp);
    // alarm at one, so the second entry raises data ready
    wr(ADDR_STAT, 32'h0000_0001, rsp);
    wr(ADDR_CTRL, 32'h0000_0040, rsp);
    put(rows[0]);
    put(rows[1]);
    lvl_wait(6'h02);
    int_is(1'b1);
    wr(ADDR_CTRL, 32'h0000_0000, rsp);
    int_is(1'b0);
    wr(ADDR_CTRL, 32'h0000_0040, rsp);
    int_is(1'b1);
    pop(rows[0].exp);
    int_is(1'b0);
    put(rows[2]);
    int_is(1'b1);
    put(rows[0]);
    pop(rows[1].exp);
    int_is(1'b1);
    pop(rows[2].exp);
    pop(rows[0].exp);
    // fill to the brim and one more, which must be refused
    wr(ADDR_CTRL, 32'h0000_0000, rsp);
    for (int i = 0; i <= DEPTH; i++) scan.push(8'(i), 8'h00, 3'h0, 3'h0, 4'(i));
    lvl_wait(6'h00);
    rd_(ADDR_CTRL, rd, rsp);
    chk(32'(rd[CTRL_FULL]), 32'h1);
    int_is(1'b1);
    for (int i = 0; i < DEPTH; i++) pop({4'h8, 4'(i), 8'(i)});
    // reset in mid-run with an entry waiting
    put(rows[0]);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    lvl = 6'h00;
    lvl_wait(6'h00);
    rd_(ADDR_CHAR, rd, rsp);
    chk(32'(rd[15]), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
